// file: include/prs_map.svh
// Address map, field positions, reset values and timing for the payload rate search block.
// Assumes a byte-wide management space with one page-select byte at 127.
`ifndef PRS_MAP_SVH
`define PRS_MAP_SVH

// ----------------------------------------------------------------
// Management addresses
// ----------------------------------------------------------------
`define PRS_ADDR_SIG_COND   8'h01
`define PRS_ADDR_PAGE_SEL   8'h7F
`define PRS_ADDR_OTN_SETUP1 8'h80
`define PRS_ADDR_SRCH_CTL   8'hC0
`define PRS_PAGE_OTN        8'h03
`define PRS_UPPER_BIT       7

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PRS_SC_RATE_HI      7
`define PRS_SC_RATE_LO      4
`define PRS_SC_LINE_LB      2
`define PRS_SC_HOST_LB      1
`define PRS_OTN_MODE_BIT    0
`define PRS_SRCH_EN_BIT     2
`define PRS_RATE_10GE       4'h1
`define PRS_RATE_OC192      4'h2
`define PRS_SC_RST          8'h10
`define PRS_OTN1_RST        8'h01
`define PRS_SRCH_CTL_RST    8'h04
`define PRS_PAGE_RST        8'h00
`define PRS_BYTE_ZERO       8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PRS_SWITCH_TIME_MS  64'd5000
`define PRS_MS_TO_US        64'd1000
`define PRS_CLK_MHZ         64'd250

`endif

// file: include/prs_pkg.sv
// Types shared by the payload rate search block and its management target.
// Assumes prs_map.svh for all numeric constants.
package prs_pkg;

  typedef logic [3:0] prs_rate_t;

  typedef enum logic [1:0] {
    PRS_INIT   = 2'h0,
    PRS_SEARCH = 2'h1,
    PRS_DONE   = 2'h3,
    PRS_FROZEN = 2'h2
  } prs_state_t;

  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } prs_wr_t;

endpackage

// file: hdl/prs_mgmt_target.sv
// Two-wire management target: address byte, pointer byte, then data bytes.
// Assumes SCL and SDA arrive asynchronously; both are synchronised here.
`timescale 1ns/10ps
`include "prs_map.svh"
module prs_mgmt_target #(
  parameter logic [6:0] DEV_ADDR = 7'h50
) (
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic           scl,
  input  wire logic           sda_in,
  input  wire logic [7:0]     rd_data,
  output prs_pkg::prs_wr_t    wr,
  output logic [7:0]          ptr,
  output logic                sda_oe
);
  import prs_pkg::*;

  logic       scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  logic       act_q, act_d, rw_q, rw_d, oe_q, oe_d;
  logic [3:0] bit_q, bit_d;
  logic [1:0] idx_q, idx_d;
  logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
  prs_wr_t    wr_q, wr_d;
  logic       start, stop, rise, fall;

  assign start = scl_s_q && sda_p_q && !sda_s_q;
  assign stop  = scl_s_q && !sda_p_q && sda_s_q;
  assign rise  = scl_s_q && !scl_p_q;
  assign fall  = !scl_s_q && scl_p_q;

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  always_comb begin
    act_d = act_q;
    rw_d  = rw_q;
    oe_d  = oe_q;
    bit_d = bit_q;
    idx_d = idx_q;
    sh_d  = sh_q;
    tx_d  = tx_q;
    ptr_d = ptr_q;
    wr_d  = '{stb: 1'b0, addr: ptr_q, data: sh_q};
    if (start) begin
      act_d = 1'b1;
      bit_d = 4'h0;
      idx_d = 2'h0;
      oe_d  = 1'b0;
    end else if (stop) begin
      act_d = 1'b0;
      oe_d  = 1'b0;
    end else if (act_q) begin
      if (rise) begin
        sh_d  = {sh_q[6:0], sda_s_q};
        bit_d = bit_q + 4'h1;
        // A read ends when the master leaves its acknowledge high
        if (bit_q == 4'h8 && rw_q && idx_q != 2'h0 && sda_s_q) begin
          act_d = 1'b0;
        end
      end
      if (fall) begin
        if (bit_q == 4'h8) begin
          oe_d = 1'b0;
          if (idx_q == 2'h0) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              oe_d  = 1'b1;
              rw_d  = sh_q[0];
              idx_d = 2'h1;
            end else begin
              act_d = 1'b0;
            end
          end else if (!rw_q) begin
            oe_d  = 1'b1;
            idx_d = 2'h2;
            if (idx_q == 2'h1) begin
              ptr_d = sh_q;
            end else begin
              wr_d.stb = 1'b1;
              ptr_d    = ptr_q + 8'h01;
            end
          end else begin
            ptr_d = ptr_q + 8'h01;
          end
        end else if (bit_q == 4'h9) begin
          bit_d = 4'h0;
          tx_d  = rd_data;
          oe_d  = rw_q && !rd_data[7];
        end else if (rw_q && idx_q != 2'h0 && bit_q != 4'h0) begin
          tx_d = {tx_q[6:0], 1'b0};
          oe_d = !tx_q[6];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    scl_m_q <= scl;
    scl_s_q <= scl_m_q;
    scl_p_q <= scl_s_q;
    sda_m_q <= sda_in;
    sda_s_q <= sda_m_q;
    sda_p_q <= sda_s_q;
    if (!rst_n) begin
      act_q <= 1'b0;
      rw_q  <= 1'b0;
      oe_q  <= 1'b0;
      bit_q <= 4'h0;
      idx_q <= 2'h0;
      sh_q  <= `PRS_BYTE_ZERO;
      tx_q  <= `PRS_BYTE_ZERO;
      ptr_q <= `PRS_BYTE_ZERO;
      wr_q  <= '0;
    end else begin
      act_q <= act_d;
      rw_q  <= rw_d;
      oe_q  <= oe_d;
      bit_q <= bit_d;
      idx_q <= idx_d;
      sh_q  <= sh_d;
      tx_q  <= tx_d;
      ptr_q <= ptr_d;
      wr_q  <= wr_d;
    end
  end

  assign wr     = wr_q;
  assign ptr    = ptr_q;
  assign sda_oe = oe_q;

endmodule

// file: hdl/prs_payload_rate_search.sv
// Startup payload rate search controller with signal conditioner loopback control.
// Assumes host-side detect and lock come from the serdes in another clock domain.
`timescale 1ns/10ps
`include "prs_map.svh"
module prs_payload_rate_search #(
  parameter logic [6:0]  DEV_ADDR      = 7'h50,
  parameter logic [31:0] SWITCH_CYCLES =
    32'(`PRS_SWITCH_TIME_MS * `PRS_MS_TO_US * `PRS_CLK_MHZ)
) (
  input  wire logic          CLK,
  input  wire logic          RSTN,
  input  wire logic          P_DOWN_RST,
  input  wire logic          TX_DISABLE,
  input  wire logic          SCL,
  input  wire logic          SDA_IN,
  output logic               SDA_OUT,
  output logic               SDA_OE,
  input  wire logic          HOST_SIGNAL_DETECT,
  input  wire logic          HOST_RATE_LOCK,
  output logic               MOD_NOT_READY,
  output logic               LASER_ON,
  output logic               TRAFFIC_ENABLE,
  output prs_pkg::prs_rate_t PAYLOAD_RATE,
  output logic               OTN_ENABLE,
  output logic               LINE_LOOPBACK,
  output logic               HOST_LOOPBACK,
  output logic               PM_COUNT_LAG
);
  import prs_pkg::*;

  if (SWITCH_CYCLES < 32'd2) begin : g_chk
    $error("SWITCH_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and reset
  // ----------------------------------------------------------------
  logic pd_m_q, pd_s_q, pd_p_q, txd_m_q, txd_s_q;
  logic sig_m_q, sig_s_q, lck_m_q, lck_s_q;
  logic rst, pd_fall;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      pd_m_q <= 1'b0;
      pd_s_q <= 1'b0;
      pd_p_q <= 1'b0;
    end else begin
      pd_m_q <= P_DOWN_RST;
      pd_s_q <= pd_m_q;
      pd_p_q <= pd_s_q;
    end
    txd_m_q <= TX_DISABLE;
    txd_s_q <= txd_m_q;
    sig_m_q <= HOST_SIGNAL_DETECT;
    sig_s_q <= sig_m_q;
    lck_m_q <= HOST_RATE_LOCK;
    lck_s_q <= lck_m_q;
  end

  // Pin falling edge acts like a power cycle, management target included
  assign pd_fall = pd_p_q && !pd_s_q;
  assign rst     = !RSTN || pd_fall;

  // ----------------------------------------------------------------
  // Management target and register decode
  // ----------------------------------------------------------------
  prs_wr_t    wr;
  logic [7:0] ptr, rd_data;
  logic [7:0] sc_q, sc_d, otn1_q, otn1_d, sctl_q, sctl_d, page_q, page_d;

  prs_mgmt_target #(
    .DEV_ADDR (DEV_ADDR)
  ) u_mgmt (
    .clk     (CLK),
    .rst_n   (!rst),
    .scl     (SCL),
    .sda_in  (SDA_IN),
    .rd_data (rd_data),
    .wr      (wr),
    .ptr     (ptr),
    .sda_oe  (SDA_OE)
  );

  // Upper half is paged; the OTN bytes live on one page only
  function automatic logic hits(input logic [7:0] a, input logic [7:0] pg,
                                input logic [7:0] target);
    hits = (a == target) && (!a[`PRS_UPPER_BIT] || pg == `PRS_PAGE_OTN);
  endfunction

  always_comb begin
    rd_data = `PRS_BYTE_ZERO;
    if (hits(ptr, page_q, `PRS_ADDR_SIG_COND)) begin
      rd_data = sc_q;
    end else if (hits(ptr, page_q, `PRS_ADDR_PAGE_SEL)) begin
      rd_data = page_q;
    end else if (hits(ptr, page_q, `PRS_ADDR_OTN_SETUP1)) begin
      rd_data = otn1_q;
    end else if (hits(ptr, page_q, `PRS_ADDR_SRCH_CTL)) begin
      rd_data = sctl_q;
    end
  end

  logic wr_sc, wr_otn1, wr_sctl, abort;
  assign wr_sc   = wr.stb && hits(wr.addr, page_q, `PRS_ADDR_SIG_COND);
  assign wr_otn1 = wr.stb && hits(wr.addr, page_q, `PRS_ADDR_OTN_SETUP1);
  assign wr_sctl = wr.stb && hits(wr.addr, page_q, `PRS_ADDR_SRCH_CTL);
  // Any of the three host actions ends the search at once
  assign abort   = wr_sc || wr_otn1 || (wr_sctl && !wr.data[`PRS_SRCH_EN_BIT]);

  // ----------------------------------------------------------------
  // Search state machine
  // ----------------------------------------------------------------
  prs_state_t  state_q, state_d;
  logic [31:0] timer_q, timer_d;
  prs_rate_t   rate;
  logic        srch_d, srch_q;

  assign rate = sc_q[`PRS_SC_RATE_HI:`PRS_SC_RATE_LO];

  always_comb begin
    state_d = state_q;
    timer_d = timer_q;
    sc_d    = sc_q;
    otn1_d  = otn1_q;
    sctl_d  = sctl_q;
    page_d  = page_q;
    unique case (state_q)
      PRS_INIT: begin
        // Not in OTN mode or disabled: the reset rate simply stands
        if (!otn1_q[`PRS_OTN_MODE_BIT] || !sctl_q[`PRS_SRCH_EN_BIT]) begin
          state_d = PRS_DONE;
        end else begin
          state_d = PRS_SEARCH;
          timer_d = SWITCH_CYCLES - 32'd1;
        end
      end
      PRS_SEARCH: begin
        if (abort) begin
          state_d = PRS_DONE;
        end else if (!sig_s_q) begin
          state_d = PRS_FROZEN;
        end else if (lck_s_q) begin
          state_d = PRS_DONE;
        end else if (timer_q == 32'd0) begin
          timer_d = SWITCH_CYCLES - 32'd1;
          sc_d[`PRS_SC_RATE_HI:`PRS_SC_RATE_LO] =
            (rate == `PRS_RATE_10GE) ? `PRS_RATE_OC192 : `PRS_RATE_10GE;
        end else begin
          timer_d = timer_q - 32'd1;
        end
      end
      PRS_FROZEN: begin
        // Timer holds so the dwell resumes where it stopped
        if (abort) begin
          state_d = PRS_DONE;
        end else if (sig_s_q) begin
          state_d = PRS_SEARCH;
        end
      end
      PRS_DONE: state_d = PRS_DONE;
    endcase
    // Host writes come last so they win over a rate toggle
    if (wr_sc) begin
      sc_d = wr.data;
    end
    if (wr_otn1) begin
      otn1_d = wr.data;
    end
    if (wr_sctl) begin
      sctl_d = wr.data;
    end
    if (wr.stb && wr.addr == `PRS_ADDR_PAGE_SEL) begin
      page_d = wr.data;
    end
  end

  assign srch_d = (state_d == PRS_SEARCH) || (state_d == PRS_FROZEN);

  always_ff @(posedge CLK) begin
    if (rst) begin
      state_q <= PRS_INIT;
      timer_q <= 32'd0;
      sc_q    <= `PRS_SC_RST;
      otn1_q  <= `PRS_OTN1_RST;
      sctl_q  <= `PRS_SRCH_CTL_RST;
      page_q  <= `PRS_PAGE_RST;
    end else begin
      state_q <= state_d;
      timer_q <= timer_d;
      sc_q    <= sc_d;
      otn1_q  <= otn1_d;
      sctl_q  <= sctl_d;
      page_q  <= page_d;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic done_d;
  assign done_d = (state_d == PRS_DONE);

  always_ff @(posedge CLK) begin
    if (rst) begin
      MOD_NOT_READY  <= 1'b1;
      LASER_ON       <= 1'b0;
      TRAFFIC_ENABLE <= 1'b0;
      PAYLOAD_RATE   <= `PRS_RATE_10GE;
      OTN_ENABLE     <= 1'b1;
      LINE_LOOPBACK  <= 1'b0;
      HOST_LOOPBACK  <= 1'b0;
      PM_COUNT_LAG   <= 1'b0;
      SDA_OUT        <= 1'b0;
      srch_q         <= 1'b0;
    end else begin
      MOD_NOT_READY  <= !done_d;
      LASER_ON       <= done_d && !txd_s_q && !pd_s_q;
      // A lock seen by the serdes means the setting matches the host data
      TRAFFIC_ENABLE <= done_d && lck_s_q && sig_s_q;
      PAYLOAD_RATE   <= sc_d[`PRS_SC_RATE_HI:`PRS_SC_RATE_LO];
      OTN_ENABLE     <= otn1_d[`PRS_OTN_MODE_BIT];
      LINE_LOOPBACK  <= sc_d[`PRS_SC_LINE_LB];
      HOST_LOOPBACK  <= sc_d[`PRS_SC_HOST_LB];
      PM_COUNT_LAG   <= srch_d;
      SDA_OUT        <= 1'b0;
      srch_q         <= srch_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_line_loop: assert property (@(posedge CLK) disable iff (rst)
    wr_sc |=> LINE_LOOPBACK == $past(wr.data[`PRS_SC_LINE_LB]))
    else $error("line loopback does not follow register write");
  chk_host_loop: assert property (@(posedge CLK) disable iff (rst)
    wr_sc |=> HOST_LOOPBACK == $past(wr.data[`PRS_SC_HOST_LB]))
    else $error("host loopback does not follow register write");
  chk_init_gate: assert property (@(posedge CLK) disable iff (rst)
    (state_q == PRS_INIT && !otn1_q[`PRS_OTN_MODE_BIT]) |=> state_q == PRS_DONE)
    else $error("search started outside OTN mode");
  chk_reset_start: assert property (@(posedge CLK)
    (rst ##1 !rst) |-> state_q == PRS_INIT && rate == `PRS_RATE_10GE && OTN_ENABLE)
    else $error("reset did not restart search at the default rate");
  chk_rate_alt: assert property (@(posedge CLK) disable iff (rst)
    (state_q == PRS_SEARCH && sig_s_q && !lck_s_q && !wr.stb && timer_q == 32'd0)
      |=> rate != $past(rate) && timer_q == SWITCH_CYCLES - 32'd1)
    else $error("rate did not alternate at dwell end");
  // A host write may legally end a frozen search, so it is left out here
  chk_freeze_hold: assert property (@(posedge CLK) disable iff (rst)
    (state_q == PRS_FROZEN && !sig_s_q && !abort) |=> $stable(timer_q) && $stable(rate))
    else $error("search advanced without host signal");
  chk_freeze_enter: assert property (@(posedge CLK) disable iff (rst)
    (state_q == PRS_SEARCH && !sig_s_q && !abort) |=> state_q == PRS_FROZEN)
    else $error("search did not freeze on host signal loss");
  chk_otn_only: assert property (@(posedge CLK) disable iff (rst)
    srch_q |-> otn1_q[`PRS_OTN_MODE_BIT] && sctl_q[`PRS_SRCH_EN_BIT])
    else $error("search running outside OTN mode or while disabled");
  chk_lock_exit: assert property (@(posedge CLK) disable iff (rst)
    (state_q == PRS_SEARCH && sig_s_q && lck_s_q) |=> state_q == PRS_DONE ##1 !MOD_NOT_READY)
    else $error("lock did not end the search");
  chk_search_dark: assert property (@(posedge CLK) disable iff (rst)
    srch_q |-> MOD_NOT_READY && !LASER_ON && !TRAFFIC_ENABLE)
    else $error("laser or ready active during search");
  // The host reads the rate field; it must agree with the rate driven to the serdes
  chk_rate_show: assert property (@(posedge CLK) disable iff (rst)
    hits(ptr, page_q, `PRS_ADDR_SIG_COND) |->
      rd_data[`PRS_SC_RATE_HI:`PRS_SC_RATE_LO] == PAYLOAD_RATE)
    else $error("rate field and rate output differ");
  chk_host_abort: assert property (@(posedge CLK) disable iff (rst)
    (srch_q && abort) |=> state_q == PRS_DONE && !MOD_NOT_READY)
    else $error("host write did not abort search");
  chk_txdis_dark: assert property (@(posedge CLK) disable iff (rst)
    txd_s_q |=> !LASER_ON)
    else $error("laser on while transmit disable is requested");
  chk_traffic_gate: assert property (@(posedge CLK) disable iff (rst)
    TRAFFIC_ENABLE |-> $past(lck_s_q) && $past(sig_s_q) && !srch_q)
    else $error("traffic enabled without host lock");
  // No disable here: this check watches the internal reset itself
  chk_pdown_reset: assert property (@(posedge CLK)
    pd_fall |=> state_q == PRS_INIT && MOD_NOT_READY && !SDA_OE)
    else $error("pin falling edge did not reset the block");
  chk_done_hold: assert property (@(posedge CLK) disable iff (rst)
    (state_q == PRS_DONE && !wr_sc) |=> state_q == PRS_DONE && $stable(rate))
    else $error("search restarted after exit");

endmodule

// file: testbench/prs_host_model.sv
// Host line card model: two-wire master and host-side serdes lock.
// Assumes SDA has a pull-up and shares the block's clock for pacing.
`timescale 1ns/10ps
module prs_host_model #(
  parameter logic [6:0] DEV = 7'h50
) (
  input  wire logic               clk,
  input  wire logic               dut_oe,
  input  wire prs_pkg::prs_rate_t rate,
  output logic                    scl,
  output logic                    sda,
  output logic                    sig_det,
  output logic                    lock,
  output int                      nacks
);
  import prs_pkg::*;
  logic      m_oe;
  logic      sig_on;
  prs_rate_t host_rate;

  // Released line floats high through the pull-up
  assign sda     = !(m_oe || dut_oe);
  assign sig_det = sig_on;

  initial begin
    scl       = 1'h1;
    m_oe      = 1'h0;
    sig_on    = 1'h0;
    host_rate = 4'h0;
    lock      = 1'h0;
    nacks     = 0;
  end

  // Lock only when host data runs at the rate the module is set to
  always @(posedge clk) begin
    lock <= sig_on && (rate === host_rate);
  end

  // ----------------------------------------------------------------
  // Two-wire master
  // ----------------------------------------------------------------
  // Data moves only mid-low phase, so it is never mistaken for a start or stop
  task automatic clk_bit(input logic oe);
    scl <= 1'h0;
    repeat (4) @(posedge clk);
    m_oe <= oe;
    repeat (4) @(posedge clk);
    scl <= 1'h1;
    repeat (8) @(posedge clk);
  endtask

  task automatic put_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(!b[i]);
    end
    clk_bit(1'h0);
    if (sda !== 1'h0) begin
      nacks++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    m_oe <= 1'h1;
    repeat (8) @(posedge clk);
    put_byte({DEV, 1'h0});
    put_byte(a);
    put_byte(d);
    clk_bit(1'h1);
    m_oe <= 1'h0;
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: testbench/tb_prs_payload_rate_search.sv
// Self-checking bench for the payload rate search block.
// Assumes prs_host_model stands in for the host line card.
`timescale 1ns/10ps
`include "prs_map.svh"
module tb_prs_payload_rate_search;
  import prs_pkg::*;
  localparam int SW = 20;
  logic      clk;
  logic      rstn;
  logic      p_down;
  logic      tx_dis;
  logic      scl;
  logic      sda;
  logic      sig;
  logic      lock;
  logic      sda_oe;
  logic      sda_out;
  logic      nr;
  logic      laser;
  logic      traffic;
  prs_rate_t rate;
  logic      otn;
  logic      llb;
  logic      hlb;
  logic      lag;
  int        nacks;
  int        miscompares;
  int        n_compared;
  int        cyc;

  prs_payload_rate_search #(.DEV_ADDR(7'h50), .SWITCH_CYCLES(32'(SW))) prs_payload_rate_search_i (
    .CLK(clk), .RSTN(rstn), .P_DOWN_RST(p_down), .TX_DISABLE(tx_dis), .SCL(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .HOST_SIGNAL_DETECT(sig),
    .HOST_RATE_LOCK(lock), .MOD_NOT_READY(nr), .LASER_ON(laser), .TRAFFIC_ENABLE(traffic),
    .PAYLOAD_RATE(rate), .OTN_ENABLE(otn), .LINE_LOOPBACK(llb), .HOST_LOOPBACK(hlb),
    .PM_COUNT_LAG(lag));

  prs_host_model #(.DEV(7'h50)) prs_host_model_i (
    .clk(clk), .dut_oe(sda_oe), .rate(rate), .scl(scl), .sda(sda), .sig_det(sig),
    .lock(lock), .nacks(nacks));

  always #2 clk = ~clk;

  // Hang guard: the full run needs well under a third of this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic do_reset(input logic s);
    @(posedge clk);
    rstn <= 1'h0;
    prs_host_model_i.sig_on <= s;
    repeat (4) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
  endtask

  // Cycles until the rate field moves, capped at lim
  task automatic wait_rate(input int lim, output int n);
    prs_rate_t r0;
    @(negedge clk);
    r0 = rate;
    n = 0;
    while (rate === r0 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    do_reset(1'h0);
    @(negedge clk);
    chk("rate", rate, `PRS_RATE_10GE);
    chk("otn", otn, 1'h1);
    chk("nr", nr, 1'h1);
    chk("laser", laser, 1'h0);
    chk("lag", lag, 1'h1);
    chk("llb", llb, 1'h0);
    chk("hlb", hlb, 1'h0);
    chk("sda_out", sda_out, 1'h0);
    chk("sda_oe", sda_oe, 1'h0);
  endtask

  task automatic t_search;
    int n;
    do_reset(1'h1);
    wait_rate(4 * SW, n);
    chk("rate", rate, `PRS_RATE_OC192);
    wait_rate(4 * SW, n);
    chk("period", 8'(n + 1), 8'(SW));
    chk("rate", rate, `PRS_RATE_10GE);
    chk("traffic", traffic, 1'h0);
    chk("nr", nr, 1'h1);
    chk("laser", laser, 1'h0);
    chk("lag", lag, 1'h1);
    repeat (SW / 2) @(posedge clk);
    prs_host_model_i.sig_on <= 1'h0;
    wait_rate(3 * SW, n);
    chk("frozen", rate, `PRS_RATE_10GE);
    @(posedge clk);
    prs_host_model_i.sig_on <= 1'h1;
    prs_host_model_i.host_rate <= `PRS_RATE_OC192;
    wait_rate(4 * SW, n);
    chk("held", 8'(n < SW), 8'h01);
    repeat (4) @(negedge clk);
    chk("nr", nr, 1'h0);
    chk("laser", laser, 1'h1);
    chk("traffic", traffic, 1'h1);
    chk("lag", lag, 1'h0);
    wait_rate(3 * SW, n);
    chk("kept", rate, `PRS_RATE_OC192);
    @(posedge clk);
    tx_dis <= 1'h1;
    repeat (4) @(negedge clk);
    chk("laser", laser, 1'h0);
    @(posedge clk);
    tx_dis <= 1'h0;
    prs_host_model_i.host_rate <= 4'h0;
  endtask

  // Page select alone must not end the search; each following write must
  task automatic t_abort;
    for (int k = 0; k < 3; k++) begin
      do_reset(1'h1);
      if (k < 2) begin
        prs_host_model_i.wr(`PRS_ADDR_PAGE_SEL, `PRS_PAGE_OTN);
      end
      chk("nr", nr, 1'h1);
      case (k)
        0: prs_host_model_i.wr(`PRS_ADDR_OTN_SETUP1, 8'h00);
        1: prs_host_model_i.wr(`PRS_ADDR_SRCH_CTL, 8'h00);
        default: prs_host_model_i.wr(`PRS_ADDR_SIG_COND, 8'h26);
      endcase
      repeat (4) @(negedge clk);
      chk("nr", nr, 1'h0);
      chk("lag", lag, 1'h0);
      if (k == 0) begin
        chk("otn", otn, 1'h0);
      end
    end
    chk("rate", rate, `PRS_RATE_OC192);
    chk("llb", llb, 1'h1);
    chk("hlb", hlb, 1'h1);
  endtask

  task automatic t_pdown;
    @(posedge clk);
    p_down <= 1'h1;
    repeat (8) @(posedge clk);
    p_down <= 1'h0;
    repeat (8) @(negedge clk);
    chk("rate", rate, `PRS_RATE_10GE);
    chk("llb", llb, 1'h0);
    chk("nr", nr, 1'h1);
    chk("sda_oe", sda_oe, 1'h0);
    // Page select is back to zero, so this address is no longer setup one
    prs_host_model_i.wr(`PRS_ADDR_OTN_SETUP1, 8'h00);
    @(negedge clk);
    chk("nr", nr, 1'h1);
  endtask

  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    p_down = 1'h0;
    tx_dis = 1'h0;
    miscompares = 0;
    n_compared = 0;
    cyc = 0;
    t_reset();
    t_search();
    t_abort();
    t_pdown();
    chk("nacks", nacks[7:0], 8'h00);
    results();
  end
endmodule
